// *** logic/cdso_params.svh ***
`ifndef CDSO_PARAMS_SVH
`define CDSO_PARAMS_SVH

// Sample word and subcode widths
`define CDSO_WORD_BITS 16
`define CDSO_SUB_BITS 8
`define CDSO_BYTE_BITS 8

// Channel slot lengths in transfer clock periods
`define CDSO_SLOT_48FS 24
`define CDSO_SLOT_64FS 32
`define CDSO_IDX_BITS 5

// Output buffer
`define CDSO_FIFO_DEPTH 4
`define CDSO_FIFO_PRIME 2

// Reset values of rate state and output levels
`define CDSO_RST_IS48 1'b0
`define CDSO_RST_LEVEL 1'b0

`endif

// *** logic/cdso_pkg.sv ***
`include "cdso_params.svh"

package cdso_pkg;

    // One stereo frame on its way to the serial line
    typedef struct packed {
        logic [`CDSO_WORD_BITS-1:0] left;
        logic [`CDSO_WORD_BITS-1:0] right;
        logic [1:0] errLeft;
        logic [1:0] errRight;
        logic [`CDSO_SUB_BITS-1:0] subcode;
    } cdso_frame_t;

    // Output controls, same order in both domains
    typedef struct packed {
        logic mute;
        logic romMode;
        logic subcodeEn;
        logic rate48;
        logic outDisable;
    } cdso_ctrl_t;

endpackage : cdso_pkg

// *** logic/cdso_serial_out.sv ***
`timescale 1ns/1ps
`include "cdso_params.svh"

// Notes on behaviour
// - Digital audio interface output is switched off by a host control bit.
// - Host bit chooses transfer clock of 48 or 64 times the sample rate.
// - Subcode insertion into the serial stream is selectable only at 48x.
// - Audio versus disc-data selection also decides whether interpolation applies.
// - Bad samples are replaced by the previous value or a neighbour mean.
// - At 48x each word goes out MSB first at the slot end.
// - At 64x each word goes out LSB first at the slot end.
// - Channel select low means left at 64x, high means left at 48x.
// - Quad rate clock runs at four times the channel select frequency.
// - Double rate clock runs at twice the channel select frequency.
// - Error flag is high for uncorrectable data, aligned with the serial data.
// - Error flag changes per channel word in audio mode, per byte otherwise.
// - Audio data is muted while the mute input is high.
// - While muted, the buffer addressing is recentred continuously, resuming after release.
// - Whole block stays in reset while the master reset input is low.
// - Serial data changes on falling transfer clock at 48x, rising at 64x.
// - A dedicated output carries the bit transfer clock.

// ****************************************
// Dual clock buffer
// ****************************************
module cdso_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic wrClk,
    input wire logic wrRst,
    input wire logic wrValid,
    output logic wrReady,
    input wire logic [WIDTH-1:0] wrData,
    input wire logic rdClk,
    input wire logic rdRst,
    output logic rdValid,
    input wire logic rdReady,
    output logic [WIDTH-1:0] rdData,
    output logic [$clog2(DEPTH):0] rdLevel
);
    localparam int AW = $clog2(DEPTH);

    function automatic logic [AW:0] grayToBin(input logic [AW:0] g);
        logic [AW:0] b;
        b = '0;
        b[AW] = g[AW];
        for (int i = AW - 1; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        return b;
    endfunction : grayToBin

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wrBin;
    logic [AW:0] wrGray;
    logic [AW:0] rdBin;
    logic [AW:0] rdGray;
    logic [AW:0] rdGrayMeta;
    logic [AW:0] rdGraySync;
    logic [AW:0] wrGrayMeta;
    logic [AW:0] wrGraySync;
    logic [AW:0] next_wrBin;
    logic [AW:0] next_rdBin;
    logic [AW:0] rdSeenBin;
    logic [AW:0] wrSeenBin;

    assign rdSeenBin = grayToBin(rdGraySync);
    assign wrSeenBin = grayToBin(wrGraySync);
    assign wrReady = (wrBin - rdSeenBin) != (AW+1)'(DEPTH);
    assign rdValid = wrGraySync != rdGray;
    assign rdData = mem[rdBin[AW-1:0]];
    assign rdLevel = wrSeenBin - rdBin;
    assign next_wrBin = wrBin + (AW+1)'(1);
    assign next_rdBin = rdBin + (AW+1)'(1);

    // ****************************************
    // Write side
    // ****************************************
    always_ff @(posedge wrClk) begin
        if (wrValid && wrReady) begin
            mem[wrBin[AW-1:0]] <= wrData;
        end
    end

    always_ff @(posedge wrClk) begin
        if (wrRst) begin
            wrBin <= '0;
            wrGray <= '0;
        end else if (wrValid && wrReady) begin
            wrBin <= next_wrBin;
            wrGray <= next_wrBin ^ (next_wrBin >> 1);
        end
    end

    always_ff @(posedge wrClk) begin
        if (wrRst) begin
            rdGrayMeta <= '0;
            rdGraySync <= '0;
        end else begin
            rdGrayMeta <= rdGray;
            rdGraySync <= rdGrayMeta;
        end
    end

    // ****************************************
    // Read side
    // ****************************************
    always_ff @(posedge rdClk) begin
        if (rdRst) begin
            rdBin <= '0;
            rdGray <= '0;
        end else if (rdValid && rdReady) begin
            rdBin <= next_rdBin;
            rdGray <= next_rdBin ^ (next_rdBin >> 1);
        end
    end

    always_ff @(posedge rdClk) begin
        if (rdRst) begin
            wrGrayMeta <= '0;
            wrGraySync <= '0;
        end else begin
            wrGrayMeta <= wrGray;
            wrGraySync <= wrGrayMeta;
        end
    end
endmodule : cdso_fifo

// ****************************************
// Serial audio output stage
// ****************************************
module cdso_serial_out (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic clkLink,
    input wire logic masterReset_n,
    input wire logic digitalOutDisable,
    input wire logic bitClockRateSelect,
    input wire logic subcodeInsertEnable,
    input wire logic romMode,
    input wire logic mute,
    input wire logic inValid,
    output logic inReady,
    input wire cdso_pkg::cdso_frame_t inFrame,
    output logic transferClockOut,
    output logic serialSampleOut,
    output logic channelSelectOut,
    output logic quadRateClockOut,
    output logic doubleRateClockOut,
    output logic uncorrectableErrorFlag,
    output logic digitalAudioIfaceOut
);
    localparam int FW = $bits(cdso_pkg::cdso_frame_t);
    localparam int LW = $clog2(`CDSO_FIFO_DEPTH) + 1;

    function automatic logic [`CDSO_WORD_BITS-1:0] meanOf(input logic [`CDSO_WORD_BITS-1:0] a,
                                                           input logic [`CDSO_WORD_BITS-1:0] b);
        logic [`CDSO_WORD_BITS:0] s;
        s = {a[`CDSO_WORD_BITS-1], a} + {b[`CDSO_WORD_BITS-1], b};
        return s[`CDSO_WORD_BITS:1];
    endfunction : meanOf

    function automatic logic [`CDSO_WORD_BITS-1:0] conceal(input logic bad, input logic audio,
                                                            input logic nextGood,
                                                            input logic [`CDSO_WORD_BITS-1:0] cur,
                                                            input logic [`CDSO_WORD_BITS-1:0] prev,
                                                            input logic [`CDSO_WORD_BITS-1:0] nxt);
        logic [`CDSO_WORD_BITS-1:0] r;
        r = cur;
        if (bad && audio) begin
            r = nextGood ? meanOf(prev, nxt) : prev;
        end
        return r;
    endfunction : conceal

    function automatic logic [`CDSO_IDX_BITS-1:0] lastIdx(input logic is48);
        return is48 ? `CDSO_IDX_BITS'(`CDSO_SLOT_48FS - 1) : `CDSO_IDX_BITS'(`CDSO_SLOT_64FS - 1);
    endfunction : lastIdx

    // Returns {data bit, error flag} for one bit position of a slot
    function automatic logic [1:0] bitOf(input logic [`CDSO_WORD_BITS-1:0] word, input logic [1:0] err,
                                         input logic [`CDSO_SUB_BITS-1:0] sub,
                                         input logic [`CDSO_IDX_BITS-1:0] idx, input logic is48,
                                         input logic subEn, input logic rom);
        logic [`CDSO_IDX_BITS-1:0] lead;
        logic [`CDSO_IDX_BITS-1:0] k;
        logic d;
        logic f;
        lead = is48 ? `CDSO_IDX_BITS'(`CDSO_SLOT_48FS - `CDSO_WORD_BITS)
                    : `CDSO_IDX_BITS'(`CDSO_SLOT_64FS - `CDSO_WORD_BITS);
        k = idx - lead;
        d = 1'b0;
        f = rom ? 1'b0 : (err[1] | err[0]);
        if (idx < lead) begin
            if (is48 && subEn && idx < `CDSO_IDX_BITS'(`CDSO_SUB_BITS)) begin
                d = sub[`CDSO_SUB_BITS-1-int'(idx)];
            end
        end else begin
            d = is48 ? word[`CDSO_WORD_BITS-1-int'(k)] : word[int'(k)];
            if (rom) begin
                f = (k < `CDSO_IDX_BITS'(`CDSO_BYTE_BITS)) ? (is48 ? err[1] : err[0])
                                                              : (is48 ? err[0] : err[1]);
            end
        end
        return {d, f};
    endfunction : bitOf

    // ****************************************
    // Reset and control crossing
    // ****************************************
    logic mrMeta;
    logic mrSync;
    logic rstSys;
    logic rstLinkMeta;
    logic rstLink;
    logic sysMuteMeta;
    logic sysMute;
    logic sysRomMeta;
    logic sysRom;
    cdso_pkg::cdso_ctrl_t ctlPins;
    cdso_pkg::cdso_ctrl_t ctlMeta;
    cdso_pkg::cdso_ctrl_t ctlSync;

    always_ff @(posedge clk_sys) begin
        mrMeta <= masterReset_n;
        mrSync <= mrMeta;
    end

    assign rstSys = srst | ~mrSync;

    always_ff @(posedge clkLink) begin
        rstLinkMeta <= rstSys;
        rstLink <= rstLinkMeta;
    end

    always_ff @(posedge clk_sys) begin
        if (rstSys) begin
            sysMuteMeta <= 1'b0;
            sysMute <= 1'b0;
            sysRomMeta <= 1'b0;
            sysRom <= 1'b0;
        end else begin
            sysMuteMeta <= mute;
            sysMute <= sysMuteMeta;
            sysRomMeta <= romMode;
            sysRom <= sysRomMeta;
        end
    end

    assign ctlPins = '{mute: mute, romMode: romMode, subcodeEn: subcodeInsertEnable,
                       rate48: ~bitClockRateSelect, outDisable: digitalOutDisable};

    always_ff @(posedge clkLink) begin
        if (rstLink) begin
            ctlMeta <= '0;
            ctlSync <= '0;
        end else begin
            ctlMeta <= ctlPins;
            ctlSync <= ctlMeta;
        end
    end

    // ****************************************
    // Concealment with one frame lookahead
    // ****************************************
    cdso_pkg::cdso_frame_t cur;
    cdso_pkg::cdso_frame_t outFrame;
    logic curValid;
    logic [`CDSO_WORD_BITS-1:0] prevLeft;
    logic [`CDSO_WORD_BITS-1:0] prevRight;
    logic fifoReady;
    logic push;
    logic take;

    assign push = curValid && inValid && !sysMute && fifoReady;
    assign take = inValid && (sysMute || !curValid || fifoReady);
    assign inReady = sysMute || !curValid || fifoReady;

    always_comb begin
        outFrame = cur;
        outFrame.left = conceal(|cur.errLeft, !sysRom, ~|inFrame.errLeft, cur.left, prevLeft,
                                inFrame.left);
        outFrame.right = conceal(|cur.errRight, !sysRom, ~|inFrame.errRight, cur.right, prevRight,
                                 inFrame.right);
    end

    always_ff @(posedge clk_sys) begin
        if (rstSys || sysMute) begin
            curValid <= 1'b0;
            cur <= '0;
        end else if (take) begin
            curValid <= 1'b1;
            cur <= inFrame;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rstSys) begin
            prevLeft <= '0;
            prevRight <= '0;
        end else if (push) begin
            prevLeft <= outFrame.left;
            prevRight <= outFrame.right;
        end
    end

    // ****************************************
    // Buffer between domains
    // ****************************************
    logic rdValid;
    logic rdReady;
    logic [FW-1:0] rdData;
    logic [LW-1:0] rdLevel;

    cdso_fifo #(
        .WIDTH(FW),
        .DEPTH(`CDSO_FIFO_DEPTH)
    ) u_fifo (
        .wrClk(clk_sys),
        .wrRst(rstSys),
        .wrValid(push),
        .wrReady(fifoReady),
        .wrData(outFrame),
        .rdClk(clkLink),
        .rdRst(rstLink),
        .rdValid(rdValid),
        .rdReady(rdReady),
        .rdData(rdData),
        .rdLevel(rdLevel)
    );

    // ****************************************
    // Link side frame fetch
    // ****************************************
    cdso_pkg::cdso_frame_t frame;
    cdso_pkg::cdso_frame_t nextFrm;
    logic nextVld;
    logic primed;
    logic phase;
    logic right;
    logic [`CDSO_IDX_BITS-1:0] idx;
    logic is48;
    logic subEn;
    logic romL;
    logic endSlot;
    logic wrap;
    logic nRight;
    logic nIs48;
    logic [`CDSO_IDX_BITS-1:0] nIdx;
    cdso_pkg::cdso_frame_t nFrame;
    logic [1:0] nBit;
    logic [`CDSO_IDX_BITS-1:0] half;
    logic [`CDSO_IDX_BITS-1:0] rem;

    // Drain while muted, then wait for half fill before playing
    assign rdReady = rdValid && (ctlSync.mute || (primed && !nextVld));

    always_ff @(posedge clkLink) begin
        if (rstLink || ctlSync.mute) begin
            primed <= 1'b0;
        end else if (rdLevel >= LW'(`CDSO_FIFO_PRIME)) begin
            primed <= 1'b1;
        end
    end

    always_ff @(posedge clkLink) begin
        if (rstLink || ctlSync.mute) begin
            nextVld <= 1'b0;
            nextFrm <= '0;
        end else if (rdReady) begin
            nextVld <= 1'b1;
            nextFrm <= rdData;
        end else if (phase && wrap) begin
            nextVld <= 1'b0;
        end
    end

    // ****************************************
    // Bit and slot timing
    // ****************************************
    assign endSlot = idx == lastIdx(is48);
    assign wrap = endSlot && right;
    assign nIdx = endSlot ? '0 : idx + `CDSO_IDX_BITS'(1);
    assign nRight = endSlot ? ~right : right;
    assign nIs48 = wrap ? ctlSync.rate48 : is48;

    always_comb begin
        nFrame = frame;
        if (wrap) begin
            nFrame = (nextVld && !ctlSync.mute) ? nextFrm : '0;
        end
    end

    always_ff @(posedge clkLink) begin
        if (rstLink) begin
            phase <= 1'b0;
            idx <= '0;
            right <= 1'b0;
        end else begin
            phase <= ~phase;
            if (phase) begin
                idx <= nIdx;
                right <= nRight;
            end
        end
    end

    // Mode changes take effect only at a frame boundary
    always_ff @(posedge clkLink) begin
        if (rstLink) begin
            is48 <= `CDSO_RST_IS48;
            subEn <= 1'b0;
            romL <= 1'b0;
            frame <= '0;
        end else if (phase && wrap) begin
            is48 <= ctlSync.rate48;
            subEn <= ctlSync.subcodeEn && ctlSync.rate48;
            romL <= ctlSync.romMode;
            frame <= nFrame;
        end
    end

    // ****************************************
    // Serial outputs
    // ****************************************
    always_comb begin
        nBit = bitOf(nRight ? nFrame.right : nFrame.left, nRight ? nFrame.errRight : nFrame.errLeft,
                     nFrame.subcode, nIdx, nIs48,
                     wrap ? (ctlSync.subcodeEn && ctlSync.rate48) : subEn,
                     wrap ? ctlSync.romMode : romL);
        half = nIs48 ? `CDSO_IDX_BITS'(`CDSO_SLOT_48FS / 2) : `CDSO_IDX_BITS'(`CDSO_SLOT_64FS / 2);
        rem = (nIdx >= half) ? nIdx - half : nIdx;
    end

    always_ff @(posedge clkLink) begin
        if (rstLink) begin
            transferClockOut <= `CDSO_RST_LEVEL;
        end else begin
            transferClockOut <= phase ? ~nIs48 : is48;
        end
    end

    always_ff @(posedge clkLink) begin
        if (rstLink) begin
            serialSampleOut <= `CDSO_RST_LEVEL;
            uncorrectableErrorFlag <= `CDSO_RST_LEVEL;
            channelSelectOut <= `CDSO_RST_LEVEL;
            quadRateClockOut <= `CDSO_RST_LEVEL;
            doubleRateClockOut <= `CDSO_RST_LEVEL;
        end else if (phase) begin
            serialSampleOut <= nBit[1];
            uncorrectableErrorFlag <= nBit[0];
            channelSelectOut <= nRight ^ nIs48;
            doubleRateClockOut <= nIdx >= half;
            quadRateClockOut <= rem >= (half >> 1);
        end
    end

    always_ff @(posedge clkLink) begin
        if (rstLink) begin
            digitalAudioIfaceOut <= `CDSO_RST_LEVEL;
        end else begin
            digitalAudioIfaceOut <= serialSampleOut && !ctlSync.outDisable;
        end
    end
endmodule : cdso_serial_out

// *** testbench/cdso_serial_out_assertions.sv ***
`timescale 1ns/1ps
// ****************************************
// Link side port checker
// ****************************************
module cdso_serial_out_checker (
    input wire logic clkLink,
    input wire logic srst,
    input wire logic masterReset_n,
    input wire logic digitalOutDisable,
    input wire logic bitClockRateSelect,
    input wire logic subcodeInsertEnable,
    input wire logic romMode,
    input wire logic mute,
    input wire logic transferClockOut,
    input wire logic serialSampleOut,
    input wire logic channelSelectOut,
    input wire logic quadRateClockOut,
    input wire logic doubleRateClockOut,
    input wire logic uncorrectableErrorFlag,
    input wire logic digitalAudioIfaceOut
);
    logic [9:0] settle;
    logic [7:0] slotCnt;
    logic settled;

    default clocking cb @(posedge clkLink);
    endclocking
    default disable iff (srst || !masterReset_n);

    // Controls unchanged for longer than a frame wrap
    always_ff @(posedge clkLink) begin
        if (srst || !masterReset_n || $changed({bitClockRateSelect, subcodeInsertEnable, romMode, mute})) begin
            settle <= 10'h000;
        end else if (settle != 10'h3FF) begin
            settle <= settle + 10'h001;
        end
    end
    always_ff @(posedge clkLink) begin
        slotCnt <= $changed(channelSelectOut) ? 8'h01 : slotCnt + 8'h01;
    end
    assign settled = settle >= 10'h258;

    property p_out_off;
        digitalOutDisable [*6] |-> !digitalAudioIfaceOut;
    endproperty
    a_out_off: assert property (p_out_off) else $error("output active while disabled");
    property p_slot;
        settled && $changed(channelSelectOut) |-> slotCnt == (bitClockRateSelect ? 8'h40 : 8'h30);
    endproperty
    a_slot: assert property (p_slot) else $error("slot length wrong");
    property p_edge48;
        settled && !bitClockRateSelect && $changed(serialSampleOut) |-> $fell(transferClockOut);
    endproperty
    a_edge48: assert property (p_edge48) else $error("data moved off falling edge");
    property p_edge64;
        settled && bitClockRateSelect && $changed(serialSampleOut) |-> $rose(transferClockOut);
    endproperty
    a_edge64: assert property (p_edge64) else $error("data moved off rising edge");
    property p_bit_clk;
        settled |-> $changed(transferClockOut);
    endproperty
    a_bit_clk: assert property (p_bit_clk) else $error("transfer clock stalled");
    property p_dbl;
        settled && $changed(channelSelectOut) |-> $fell(doubleRateClockOut);
    endproperty
    a_dbl: assert property (p_dbl) else $error("double clock out of step");
    property p_quad;
        settled && $changed(doubleRateClockOut) |-> $fell(quadRateClockOut);
    endproperty
    a_quad: assert property (p_quad) else $error("quad clock out of step");
    property p_flag;
        settled && !romMode && $changed(uncorrectableErrorFlag) |-> $changed(channelSelectOut);
    endproperty
    a_flag: assert property (p_flag) else $error("flag moved inside a word");
    property p_mute;
        settled && mute |-> !serialSampleOut && $changed(transferClockOut);
    endproperty
    a_mute: assert property (p_mute) else $error("data while muted");
endmodule : cdso_serial_out_checker

bind cdso_serial_out cdso_serial_out_checker i_cdso_serial_out_checker (
    .clkLink(clkLink), .srst(srst), .masterReset_n(masterReset_n), .digitalOutDisable(digitalOutDisable),
    .bitClockRateSelect(bitClockRateSelect), .subcodeInsertEnable(subcodeInsertEnable), .romMode(romMode),
    .mute(mute), .transferClockOut(transferClockOut), .serialSampleOut(serialSampleOut),
    .channelSelectOut(channelSelectOut), .quadRateClockOut(quadRateClockOut),
    .doubleRateClockOut(doubleRateClockOut), .uncorrectableErrorFlag(uncorrectableErrorFlag),
    .digitalAudioIfaceOut(digitalAudioIfaceOut)
);

// *** testbench/cdso_sink_model.sv ***
`timescale 1ns/1ps
// ****************************************
// Serial sample receiver
// ****************************************
module cdso_sink_model (
    input wire logic clkLink,
    input wire logic rate48,
    input wire logic bitClk,
    input wire logic dataIn,
    input wire logic chanSel,
    input wire logic errIn,
    output logic [71:0] decoded,
    output logic commit
);
    logic bitClkQ = 1'b0;
    logic chanQ = 1'b0;
    logic [23:0] raw;
    logic [15:0] word;
    logic [15:0] errBits;
    logic [39:0] leftPart;

    always @(posedge clkLink) begin
        bitClkQ <= bitClk;
        commit <= 1'b0;
        // Sample on the quiet edge: rise at 48x, fall at 64x
        if (bitClk != bitClkQ && bitClk == rate48) begin
            chanQ <= chanSel;
            raw <= {raw[22:0], dataIn};
            word <= rate48 ? {word[14:0], dataIn} : {dataIn, word[15:1]};
            errBits <= rate48 ? {errBits[14:0], errIn} : {errIn, errBits[15:1]};
            if (chanSel != chanQ) begin
                // Left is high at 48x, low at 64x
                if (chanQ == rate48) begin
                    leftPart <= {word, errBits, raw[23:16]};
                end else begin
                    decoded <= {leftPart[39:24], word, leftPart[23:8], errBits, leftPart[7:0]};
                    commit <= 1'b1;
                end
            end
        end
    end
endmodule : cdso_sink_model

// *** testbench/tb_cdso_serial_out.sv ***
`timescale 1ns/1ps
// ****************************************
// Frames in, decoded slots compared
// ****************************************
module tb_cdso_serial_out;
    logic clk_sys, clkLink, srst, masterReset_n, digitalOutDisable, bitClockRateSelect;
    logic subcodeInsertEnable, romMode, mute, inValid, inReady, commit;
    logic transferClockOut, serialSampleOut, channelSelectOut, quadRateClockOut;
    logic doubleRateClockOut, uncorrectableErrorFlag, digitalAudioIfaceOut;
    cdso_pkg::cdso_frame_t inFrame;
    cdso_pkg::cdso_frame_t fq[$];
    logic [71:0] decoded;
    logic [71:0] got[$];
    logic [71:0] eq[$];
    logic [2:0] modes[3] = '{3'b001, 3'b111, 3'b011};
    cdso_pkg::cdso_frame_t tbl[$] = '{{16'h8421, 16'h1357, 2'b10, 2'b01, 8'h5A},
        {16'hFFFE, 16'h0001, 2'b00, 2'b11, 8'hC3}, {16'h7F80, 16'hA55A, 2'b01, 2'b00, 8'h0F}};
    cdso_pkg::cdso_frame_t aud[$] = '{{16'h0100, 16'hFF00, 4'h0, 8'h00}, {16'h7777, 16'h1111, 4'hF, 8'h00},
        {16'h0300, 16'h0300, 4'h0, 8'h00}, {16'h7777, 16'h0500, 4'hC, 8'h00},
        {16'h7777, 16'h0600, 4'hC, 8'h00}, {16'h0500, 16'h0700, 4'h0, 8'h00}};
    logic [71:0] audExp[$] = '{72'h0100_FF00_0000_0000_00, 72'h0200_0100_FFFF_FFFF_00,
        72'h0300_0300_0000_0000_00, 72'h0300_0500_FFFF_0000_00, 72'h0400_0600_FFFF_0000_00,
        72'h0500_0700_0000_0000_00};
    int errors = 0;
    int checked = 0;
    int cycles = 0;

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    initial begin
        clkLink = 1'b0;
        #7;
        forever #15 clkLink = ~clkLink;
    end

    cdso_serial_out i_cdso_serial_out (.clk_sys(clk_sys), .srst(srst), .clkLink(clkLink),
        .masterReset_n(masterReset_n), .digitalOutDisable(digitalOutDisable),
        .bitClockRateSelect(bitClockRateSelect), .subcodeInsertEnable(subcodeInsertEnable), .romMode(romMode),
        .mute(mute), .inValid(inValid), .inReady(inReady), .inFrame(inFrame), .transferClockOut(transferClockOut),
        .serialSampleOut(serialSampleOut), .channelSelectOut(channelSelectOut), .quadRateClockOut(quadRateClockOut),
        .doubleRateClockOut(doubleRateClockOut), .uncorrectableErrorFlag(uncorrectableErrorFlag),
        .digitalAudioIfaceOut(digitalAudioIfaceOut));
    cdso_sink_model i_cdso_sink_model (.clkLink(clkLink), .rate48(!bitClockRateSelect), .bitClk(transferClockOut),
        .dataIn(serialSampleOut), .chanSel(channelSelectOut), .errIn(uncorrectableErrorFlag),
        .decoded(decoded), .commit(commit));

    // Keep only frames that carry data
    always @(posedge clkLink) begin
        if (commit === 1'b1 && decoded[71:40] != 32'h0) begin
            got.push_back(decoded);
        end
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 80000) begin
            errors++;
            close_out();
        end
    end

    task automatic close_out();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : close_out

    task automatic chk(input string what, input logic [71:0] seen, input logic [71:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    function automatic logic [15:0] msk(input logic [1:0] e, input logic rom);
        return rom ? {{8{e[1]}}, {8{e[0]}}} : {16{|e}};
    endfunction : msk

    task automatic send(input cdso_pkg::cdso_frame_t f);
        int n;
        inValid <= 1'b1;
        inFrame <= f;
        n = 0;
        do begin
            @(negedge clk_sys);
            n++;
        end while (inReady !== 1'b1 && n < 5000);
        @(posedge clk_sys);
    endtask : send

    // Mute drops leftovers while the modes change
    task automatic setup(input logic [2:0] m);
        @(posedge clk_sys);
        mute <= 1'b1;
        {bitClockRateSelect, subcodeInsertEnable, romMode} <= m;
        digitalOutDisable <= m[2];
        repeat (3000) @(posedge clk_sys);
        mute <= 1'b0;
        repeat (20) @(posedge clk_sys);
        got.delete();
    endtask : setup

    task automatic load(input logic rom, input logic sub);
        fq = tbl;
        eq.delete();
        foreach (tbl[i]) begin
            eq.push_back({tbl[i].left, tbl[i].right, msk(tbl[i].errLeft, rom), msk(tbl[i].errRight, rom),
                sub ? tbl[i].subcode : 8'h00});
        end
    endtask : load

    // Trailing zero frame releases the held last frame
    task automatic play(input string name);
        int n;
        foreach (fq[i]) send(fq[i]);
        send(44'h0);
        inValid <= 1'b0;
        n = 0;
        while (got.size() < eq.size() && n < 8000) begin
            @(posedge clk_sys);
            n++;
        end
        chk("count", 72'(got.size()), 72'(eq.size()));
        foreach (eq[i]) chk(name, got[i], eq[i]);
        $display("test %s done", name);
    endtask : play

    initial begin
        {srst, masterReset_n, digitalOutDisable, bitClockRateSelect} = 4'h8;
        {subcodeInsertEnable, romMode, mute, inValid} = 4'h0;
        inFrame = '0;
        repeat (5) @(posedge clk_sys);
        srst <= 1'b0;
        repeat (15) @(posedge clk_sys);
        masterReset_n <= 1'b1;
        for (int m = 0; m < 3; m++) begin
            setup(modes[m]);
            load(1'b1, modes[m][1] & ~modes[m][2]);
            play("rom");
        end
        setup(3'b000);
        fq = aud;
        eq = audExp;
        play("audio");
        masterReset_n <= 1'b0;
        repeat (20) @(posedge clk_sys);
        chk("reset", 72'({inReady, transferClockOut, serialSampleOut, channelSelectOut, quadRateClockOut,
            doubleRateClockOut, uncorrectableErrorFlag, digitalAudioIfaceOut}), 72'h80);
        masterReset_n <= 1'b1;
        $display("test reset done");
        setup(3'b101);
        mute <= 1'b1;
        repeat (10) @(posedge clk_sys);
        foreach (tbl[i]) send(tbl[i]);
        inValid <= 1'b0;
        repeat (2000) @(posedge clk_sys);
        chk("muted", 72'(got.size()), 72'h0);
        mute <= 1'b0;
        repeat (20) @(posedge clk_sys);
        load(1'b1, 1'b0);
        play("resume");
        close_out();
    end
endmodule : tb_cdso_serial_out
